/* File: core/cdu_pkg.sv */
package cdu_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_UPDATE_CONTROL = 8'h90;
  localparam logic [7:0] ADDR_USER_DOWNLOAD = 8'hD8;
  localparam logic [7:0] CFG_LAST_ADDR = 8'h9F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UPD_TRANSPARENT_BIT = 0;
  localparam int UPD_APPLY_BIT = 1;
  localparam int UPD_ERASE_EN_BIT = 2;
  localparam int DNLD_START_BIT = 0;

  // ----------------------------------------------------------------
  // Nonvolatile map
  // ----------------------------------------------------------------
  localparam logic [15:0] NV_BASE = 16'hF800;
  localparam logic [15:0] NV_CFG_LAST = 16'hF89F;
  localparam logic [15:0] NV_RSVD_LAST = 16'hF8FF;
  localparam logic [15:0] NV_USER_LAST = 16'hF9FF;
  localparam logic [15:0] NV_SEQ_BASE = 16'hFA00;
  localparam logic [15:0] NV_LAST = 16'hFBFF;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'hFE;
  localparam logic [7:0] NV_BLANK = 8'hFF;
  localparam logic [7:0] UPD_RESET = 8'h00;
  localparam int PAGE_BYTES = 32;
  localparam int SEQ_WORD_BITS = 64;
  localparam int SEQ_STATES = 63;

  // ----------------------------------------------------------------
  // Timing at 20 MHz
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int FIRST_STATE_DELAY_US = 500;
  localparam int FIRST_STATE_DELAY_CYC = (FIRST_STATE_DELAY_US * (CLK_HZ / 1000000));
  localparam int STATE_FETCH_US = 10;
  localparam int STATE_FETCH_CYC = STATE_FETCH_US * (CLK_HZ / 1000000);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_COPY_A = 6'b000010,
    ST_COPY_B = 6'b000100,
    ST_WAIT_SEQ = 6'b001000,
    ST_SEQ_FETCH = 6'b010000,
    ST_READY = 6'b100000
  } cdu_state_t;

endpackage : cdu_pkg

/* File: core/cdu_latch_pair.sv */
module cdu_latch_pair #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Controls
  input wire logic load_a,
  input wire logic [WIDTH-1:0] data_a,
  input wire logic transparent,
  input wire logic load_b,
  // Outputs
  output logic [WIDTH-1:0] primary_q,
  output logic [WIDTH-1:0] shadow_q
);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      primary_q <= '0;
    end else if (load_a) begin
      primary_q <= data_a;
    end
  end

  // Shadow follows primary one cycle later, so A is always written first
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shadow_q <= '0;
    end else if (load_b || transparent) begin
      shadow_q <= primary_q;
    end
  end

endmodule : cdu_latch_pair

/* File: core/cdu_config_loader.sv */
// Function
// - Leaving reset, copy nonvolatile configuration into every primary latch.
// - After all primaries load, copy primaries to shadows in one step.
// - Fetch first sequencer state 0.5 ms after configuration load completes.
// - Refuse every bus access with not-acknowledge until load finishes.
// - Updates write the primary latch first, then the shadow.
// - Control bit 0 set makes writes take effect at once.
// - Control bit 0 clear makes writes change only primary latches.
// - Writing control bit 1 gives one pulse loading all shadows.
// - Erase-enable high sets page to ones; low leaves page unchanged.
// - Nonvolatile writes leave working registers until a download.
// - Sequencer store holds 64-bit words, 63 usable states, one reserved.
// - When state conditions are met, fetch next word taking about 10 us.
// - First byte of each write loads the address pointer.
// - F800-F9FF hold config, user, faults; FA00-FBFF hold states.
// - Nonvolatile byte writes only land on blank locations.
// - Sixteen 32-byte pages; pages 0-4 mirror registers; 5-7 reserved.
// - Pages 8-11 user; pages 12-15 user or fault records.
// - Download-trigger bit 0 reloads pages 0-4 into working registers.
// - While sequencer runs, accesses to state range are not-acknowledged.
// - Active fault recorder: config/user accesses acked, reads junk, writes dropped.
// - No trigger states means recorder disabled and access allowed.
// - Page erase enable is control bit 2 at 0x90.
// - Erase command 0xFE acts on page given by prior word write.
module cdu_config_loader #(
  parameter int NREG = 160,
  parameter int NV_BYTES = 1024,
  parameter int FIRST_DELAY = cdu_pkg::FIRST_STATE_DELAY_CYC,
  parameter int FETCH_CYC = cdu_pkg::STATE_FETCH_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Decoded bus transactions
  input wire logic pointer_wr,
  input wire logic [7:0] pointer_byte,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic nv_addr_wr,
  input wire logic [15:0] nv_addr,
  input wire logic nv_wr,
  input wire logic [7:0] nv_wdata,
  input wire logic nv_rd,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_byte,
  output logic bus_ack,
  output logic [7:0] rdata,
  // Sequencer and fault recorder
  input wire logic seq_running,
  input wire logic fault_rec_enabled,
  input wire logic fault_trigger_any,
  input wire logic seq_advance,
  input wire logic [5:0] seq_next_state,
  output logic [63:0] seq_word,
  output logic seq_word_valid,
  // Configuration outputs
  output logic [NREG*8-1:0] active_config,
  output logic load_done
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  localparam int NVA = $clog2(NV_BYTES);
  logic [7:0] nv_mem [NV_BYTES];
  logic [7:0] pointer_reg;
  logic [15:0] nv_ptr_reg;
  logic [7:0] upd_reg;
  logic [7:0] rdata_reg;
  cdu_pkg::cdu_state_t state_reg;
  logic [7:0] idx_reg;
  logic [31:0] timer_reg;
  logic [5:0] seq_state_reg;
  logic [2:0] seq_byte_reg;
  logic [63:0] seq_word_reg;
  logic seq_valid_reg;
  logic apply_pulse;
  logic [NREG*8-1:0] primary_bus;
  logic [NVA-1:0] nv_off;
  logic in_seq;
  logic in_cfg;
  logic recorder_busy;
  logic nv_allowed;
  logic booted_reg;
  logic nv_store_ok;

  assign nv_off = nv_ptr_reg[NVA-1:0];
  assign in_seq = (nv_ptr_reg >= cdu_pkg::NV_SEQ_BASE) && (nv_ptr_reg <= cdu_pkg::NV_LAST);
  assign in_cfg = (nv_ptr_reg >= cdu_pkg::NV_BASE) && (nv_ptr_reg <= cdu_pkg::NV_USER_LAST);
  assign recorder_busy = fault_rec_enabled && fault_trigger_any;
  assign nv_allowed = in_cfg && !recorder_busy;
  // Recorder-owned range reads as blank and drops writes
  assign nv_store_ok = nv_allowed || in_seq;

  // ----------------------------------------------------------------
  // Acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    if (!load_done) begin
      bus_ack = 1'b0;
    end else if ((nv_rd || nv_wr) && in_seq && seq_running) begin
      bus_ack = 1'b0;
    end else begin
      bus_ack = 1'b1;
    end
  end

  assign load_done = (state_reg == cdu_pkg::ST_WAIT_SEQ) || (state_reg == cdu_pkg::ST_SEQ_FETCH)
                     || (state_reg == cdu_pkg::ST_READY);

  // ----------------------------------------------------------------
  // Address pointer and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pointer_reg <= 8'h00;
    end else if (pointer_wr && load_done) begin
      pointer_reg <= pointer_byte;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      nv_ptr_reg <= cdu_pkg::NV_BASE;
    end else if (nv_addr_wr && load_done) begin
      nv_ptr_reg <= nv_addr;
    end else if ((nv_wr || nv_rd) && bus_ack) begin
      nv_ptr_reg <= nv_ptr_reg + 16'h0001;
    end
  end

  // Apply bit is self-clearing; only bits 0 and 2 are stored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      upd_reg <= cdu_pkg::UPD_RESET;
    end else if (reg_wr && load_done && pointer_reg == cdu_pkg::ADDR_UPDATE_CONTROL) begin
      upd_reg <= cdu_pkg::UPD_RESET;
      upd_reg[cdu_pkg::UPD_TRANSPARENT_BIT] <= reg_wdata[cdu_pkg::UPD_TRANSPARENT_BIT];
      upd_reg[cdu_pkg::UPD_ERASE_EN_BIT] <= reg_wdata[cdu_pkg::UPD_ERASE_EN_BIT];
    end
  end

  assign apply_pulse = reg_wr && load_done && pointer_reg == cdu_pkg::ADDR_UPDATE_CONTROL
                       && reg_wdata[cdu_pkg::UPD_APPLY_BIT];

  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------
  logic user_dl;
  assign user_dl = reg_wr && state_reg == cdu_pkg::ST_READY
                   && pointer_reg == cdu_pkg::ADDR_USER_DOWNLOAD
                   && reg_wdata[cdu_pkg::DNLD_START_BIT];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= cdu_pkg::ST_IDLE;
      idx_reg <= 8'h00;
      timer_reg <= '0;
      seq_state_reg <= 6'h00;
      seq_byte_reg <= 3'h0;
    end else begin
      case (state_reg)
        cdu_pkg::ST_IDLE: begin
          idx_reg <= 8'h00;
          state_reg <= cdu_pkg::ST_COPY_A;
        end
        cdu_pkg::ST_COPY_A: begin
          if (idx_reg == 8'(NREG - 1)) begin
            state_reg <= cdu_pkg::ST_COPY_B;
          end else begin
            idx_reg <= idx_reg + 8'h01;
          end
        end
        cdu_pkg::ST_COPY_B: begin
          timer_reg <= '0;
          state_reg <= booted_reg ? cdu_pkg::ST_READY : cdu_pkg::ST_WAIT_SEQ;
        end
        cdu_pkg::ST_WAIT_SEQ: begin
          if (timer_reg == 32'(FIRST_DELAY - 1)) begin
            timer_reg <= '0;
            seq_state_reg <= 6'h00;
            seq_byte_reg <= 3'h0;
            state_reg <= cdu_pkg::ST_SEQ_FETCH;
          end else begin
            timer_reg <= timer_reg + 32'h1;
          end
        end
        cdu_pkg::ST_SEQ_FETCH: begin
          // Paced so a whole fetch spans FETCH_CYC cycles; the last eight move bytes
          timer_reg <= timer_reg + 32'h1;
          if (timer_reg >= 32'(FETCH_CYC - 8)) begin
            seq_byte_reg <= seq_byte_reg + 3'h1;
            if (seq_byte_reg == 3'h7) begin
              state_reg <= cdu_pkg::ST_READY;
            end
          end
        end
        default: begin
          if (user_dl) begin
            idx_reg <= 8'h00;
            state_reg <= cdu_pkg::ST_COPY_A;
          end else if (seq_advance && seq_next_state < 6'(cdu_pkg::SEQ_STATES)) begin
            timer_reg <= '0;
            seq_byte_reg <= 3'h0;
            seq_state_reg <= seq_next_state;
            state_reg <= cdu_pkg::ST_SEQ_FETCH;
          end
        end
      endcase
    end
  end

  // Set by the power-up image; a user reload then skips the first-state fetch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      booted_reg <= 1'b0;
    end else if (state_reg == cdu_pkg::ST_COPY_B) begin
      booted_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer word fetch
  // ----------------------------------------------------------------
  // Word assembled from the state region, byte 0 lowest
  logic [NVA-1:0] seq_addr;
  logic seq_take;
  assign seq_addr = NVA'(16'h0200 + {7'h00, seq_state_reg, seq_byte_reg});
  assign seq_take = state_reg == cdu_pkg::ST_SEQ_FETCH && timer_reg >= 32'(FETCH_CYC - 8);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      seq_word_reg <= '0;
    end else if (seq_take) begin
      seq_word_reg[seq_byte_reg*8 +: 8] <= nv_mem[seq_addr];
    end
  end

  // Strobe only once the top byte is in
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      seq_valid_reg <= 1'b0;
    end else begin
      seq_valid_reg <= seq_take && seq_byte_reg == 3'h7;
    end
  end

  assign seq_word = seq_word_reg;
  assign seq_word_valid = seq_valid_reg;

  // ----------------------------------------------------------------
  // Latches
  // ----------------------------------------------------------------
  logic copy_b;
  logic host_latch_wr;
  logic latch_live;
  assign copy_b = state_reg == cdu_pkg::ST_COPY_B || apply_pulse;

  // Open from load_done on, first-fetch wait included: an acknowledged write to a latch address is never lost
  assign host_latch_wr = reg_wr && load_done
                         && pointer_reg != cdu_pkg::ADDR_UPDATE_CONTROL
                         && pointer_reg != cdu_pkg::ADDR_USER_DOWNLOAD;
  // Closed during a reload so the shadows change only in the final step
  assign latch_live = upd_reg[cdu_pkg::UPD_TRANSPARENT_BIT] && load_done;

  for (genvar g = 0; g < NREG; g++) begin : g_latch
    logic la;
    logic [7:0] da;
    always_comb begin
      la = 1'b0;
      da = reg_wdata;
      if (state_reg == cdu_pkg::ST_COPY_A && idx_reg == 8'(g)) begin
        la = 1'b1;
        da = nv_mem[g];
      end else if (host_latch_wr && pointer_reg == 8'(g)) begin
        la = 1'b1;
      end
    end
    cdu_latch_pair #(.WIDTH(8)) u_pair (
      .core_clk(core_clk),
      .resetn(resetn),
      .load_a(la),
      .data_a(da),
      .transparent(latch_live),
      .load_b(copy_b),
      .primary_q(primary_bus[g*8 +: 8]),
      .shadow_q(active_config[g*8 +: 8])
    );
  end

  // ----------------------------------------------------------------
  // Nonvolatile array
  // ----------------------------------------------------------------
  // Erase and write never touch the latches; only a download does
  logic erase_go;
  assign erase_go = cmd_wr && load_done && cmd_byte == cdu_pkg::CMD_PAGE_ERASE
                    && upd_reg[cdu_pkg::UPD_ERASE_EN_BIT] && (nv_allowed
                    || (in_seq && !seq_running));

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NV_BYTES; i++) begin
      if (erase_go && (NVA'(i) >> 5) == (nv_off >> 5)) begin
        nv_mem[i] <= cdu_pkg::NV_BLANK;
      end else if (nv_wr && bus_ack && NVA'(i) == nv_off
                   && nv_store_ok
                   && nv_mem[i] == cdu_pkg::NV_BLANK) begin
        nv_mem[i] <= nv_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else if (nv_rd && bus_ack) begin
      rdata_reg <= nv_store_ok ? nv_mem[nv_off] : cdu_pkg::NV_BLANK;
    end else if (reg_wr == 1'b0 && pointer_reg == cdu_pkg::ADDR_UPDATE_CONTROL) begin
      rdata_reg <= upd_reg;
    end else if (pointer_reg < 8'(NREG)) begin
      rdata_reg <= primary_bus[pointer_reg*8 +: 8];
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata = rdata_reg;

endmodule : cdu_config_loader

/* File: testbench/cdu_loader_assertions.sv */
module cdu_loader_assertions #(
  parameter int NREG = 160,
  parameter int FIRST_DELAY = 10000,
  parameter int FETCH_CYC = 200
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bus
  input wire logic pointer_wr,
  input wire logic [7:0] pointer_byte,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic nv_addr_wr,
  input wire logic [15:0] nv_addr,
  input wire logic nv_wr,
  input wire logic nv_rd,
  input wire logic bus_ack,
  input wire logic [7:0] rdata,
  // Sequencer and config
  input wire logic seq_running,
  input wire logic fault_rec_enabled,
  input wire logic fault_trigger_any,
  input wire logic seq_advance,
  input wire logic [5:0] seq_next_state,
  input wire logic seq_word_valid,
  input wire logic [NREG*8-1:0] active_config,
  input wire logic load_done
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FLO = FIRST_DELAY;
  localparam int FHI = FIRST_DELAY + FETCH_CYC + 4;
  localparam int SLO = FETCH_CYC - 2;
  localparam int SHI = FETCH_CYC + 4;
  logic [7:0] ptr_q;
  logic [7:0] upd_q;
  logic [15:0] nvp;
  logic seen;
  logic busy;
  logic seqr;
  // ----------------------------------------
  // Shadow copies of the pointers and the update control register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= 8'h00;
      upd_q <= 8'h00;
    end else begin
      if (pointer_wr && bus_ack) ptr_q <= pointer_byte;
      if (reg_wr && bus_ack && ptr_q == 8'h90) upd_q <= reg_wdata;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) nvp <= 16'h0000;
    else if (nv_addr_wr && bus_ack) nvp <= nv_addr;
    else if ((nv_rd || nv_wr) && bus_ack) nvp <= nvp + 16'h0001;
  end
  // Only the first rise after reset starts the first fetch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) seen <= 1'h0;
    else if (load_done) seen <= 1'h1;
  end
  assign busy = fault_rec_enabled && fault_trigger_any && nvp >= 16'hF800 && nvp <= 16'hF9FF;
  assign seqr = seq_running && nvp >= 16'hFA00 && nvp <= 16'hFBFF;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_staged;
    reg_wr && bus_ack && ptr_q != 8'h90 && ptr_q != 8'hD8 && !upd_q[0];
  endsequence
  sequence s_hold;
    $stable(active_config) [*2];
  endsequence
  chk_nack_early: assert property (!load_done |-> !bus_ack)
    else $error("access acknowledged before load");
  chk_first_fetch: assert property ($rose(load_done) && !seen |-> ##[FLO:FHI] seq_word_valid)
    else $error("first state fetch late");
  chk_fetch_time: assert property (seq_advance && seq_next_state < 6'h3F && load_done
    |-> ##[SLO:SHI] seq_word_valid) else $error("state fetch time wrong");
  chk_reserved_state: assert property (seq_advance && seq_next_state == 6'h3F
    |=> !seq_word_valid [*8]) else $error("reserved state fetched");
  chk_valid_pulse: assert property (seq_word_valid |=> !seq_word_valid)
    else $error("word valid longer than one cycle");
  chk_staged_hold: assert property (s_staged |=> s_hold)
    else $error("staged write changed active config");
  chk_transparent_write: assert property (reg_wr && bus_ack && ptr_q < NREG && upd_q[0]
    && ptr_q != 8'h90 |-> ##2 active_config[ptr_q*8 +: 8] == $past(reg_wdata, 2))
    else $error("write not live");
  chk_seq_nack: assert property (load_done && seqr && (nv_rd || nv_wr) |-> !bus_ack)
    else $error("state range access acknowledged");
  chk_rec_ack: assert property (load_done && busy && (nv_rd || nv_wr) |-> bus_ack)
    else $error("recorder range access refused");
  chk_rec_junk: assert property (busy && nv_rd && bus_ack |-> ##[1:2] rdata == 8'hFF)
    else $error("recorder range read returned data");
endmodule : cdu_loader_assertions

bind cdu_config_loader cdu_loader_assertions #(.NREG(NREG), .FIRST_DELAY(FIRST_DELAY),
  .FETCH_CYC(FETCH_CYC)) u_chk (.*);

/* File: testbench/cdu_host_model.sv */
module cdu_host_model (
  // Clock and answer
  input wire logic core_clk,
  input wire logic bus_ack,
  // Request
  output logic [5:0] stb,
  output logic [15:0] addr,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    stb = 6'h00;
    addr = 16'h0000;
    wdata = 8'h00;
  end
  // Entered just after a rising edge; ack is taken at the edge that samples the strobe
  task automatic xfer(input int k, input logic [15:0] a, input logic [7:0] d, output logic ack);
    stb[k] = 1'h1;
    addr = a;
    wdata = d;
    @(posedge core_clk);
    ack = bus_ack;
    #1;
    stb = 6'h00;
    // Released lines must not keep the last value
    addr = ~a;
    wdata = ~d;
  endtask : xfer
endmodule : cdu_host_model

/* File: testbench/test_config_download_and_update.sv */
module test_config_download_and_update;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NR = 8;
  localparam int PTR = 0;
  localparam int REG = 1;
  localparam int NVA = 2;
  localparam int NVW = 3;
  localparam int NVR = 4;
  localparam int CMD = 5;
  logic core_clk, resetn, ack, bus_ack, load_done, seq_word_valid;
  logic seq_running, fault_rec_enabled, fault_trigger_any, seq_advance;
  logic [5:0] stb, seq_next_state;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic [63:0] seq_word;
  logic [NR*8-1:0] active_config, snap;
  int n_mismatch, compares, cyc, hits;
  cdu_config_loader #(.NREG(NR), .FIRST_DELAY(20), .FETCH_CYC(16)) u_dut (
    .core_clk(core_clk), .resetn(resetn),
    .pointer_wr(stb[0]), .pointer_byte(wdata), .reg_wr(stb[1]), .reg_wdata(wdata),
    .nv_addr_wr(stb[2]), .nv_addr(addr), .nv_wr(stb[3]), .nv_wdata(wdata),
    .nv_rd(stb[4]), .cmd_wr(stb[5]), .cmd_byte(wdata), .bus_ack(bus_ack), .rdata(rdata),
    .seq_running(seq_running), .fault_rec_enabled(fault_rec_enabled),
    .fault_trigger_any(fault_trigger_any), .seq_advance(seq_advance),
    .seq_next_state(seq_next_state), .seq_word(seq_word), .seq_word_valid(seq_word_valid),
    .active_config(active_config), .load_done(load_done));
  cdu_host_model u_host (.core_clk(core_clk), .bus_ack(bus_ack), .stb(stb), .addr(addr),
    .wdata(wdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic go(input int k, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    u_host.xfer(k, a, d, ack);
  endtask : go
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    go(PTR, 16'h0000, a);
    go(REG, 16'h0000, d);
  endtask : wr
  task automatic rd_nv(input logic [15:0] a, input logic [7:0] exp);
    go(NVA, a, 8'h00);
    go(NVR, 16'h0000, 8'h00);
    // Read data is replaced from the register pointer on the next edge
    chk8(rdata, exp);
  endtask : rd_nv
  task automatic erase(input logic [15:0] a);
    go(NVA, a, 8'h00);
    go(CMD, 16'h0000, 8'hFE);
    repeat (40) @(posedge core_clk);
  endtask : erase
  task automatic advance(input logic [5:0] s);
    @(posedge core_clk);
    #1;
    seq_next_state = s;
    seq_advance = 1'h1;
    @(posedge core_clk);
    #1;
    seq_advance = 1'h0;
    hits = 0;
    repeat (30) begin
      @(posedge core_clk);
      #1;
      if (seq_word_valid === 1'h1) hits++;
    end
  endtask : advance
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {resetn, seq_running, fault_rec_enabled, fault_trigger_any, seq_advance} = 5'h00;
    seq_next_state = 6'h00;
    repeat (12) @(posedge core_clk);
    #1;
    resetn = 1'h1;
    go(PTR, 16'h0000, 8'h90);
    chk1(ack, 1'h0);
    for (int i = 0; i < 40 && load_done !== 1'h1; i++) @(posedge core_clk);
    chk1(load_done, 1'h1);
    $display("power-up load done");
    wr(8'h90, 8'h00);
    snap = active_config;
    wr(8'h03, 8'hA5);
    repeat (3) @(posedge core_clk);
    chk8(active_config[31:24], snap[31:24]);
    go(PTR, 16'h0000, 8'h03);
    @(posedge core_clk);
    #1;
    chk8(rdata, 8'hA5);
    wr(8'h90, 8'h02);
    repeat (3) @(posedge core_clk);
    chk8(active_config[31:24], 8'hA5);
    wr(8'h90, 8'h01);
    wr(8'h04, 8'h3C);
    repeat (2) @(posedge core_clk);
    chk8(active_config[39:32], 8'h3C);
    $display("latch updates done");
    wr(8'h90, 8'h04);
    erase(16'hF900);
    rd_nv(16'hF900, 8'hFF);
    go(NVA, 16'hF900, 8'h00);
    go(NVW, 16'h0000, 8'h12);
    go(NVA, 16'hF900, 8'h00);
    go(NVW, 16'h0000, 8'h34);
    rd_nv(16'hF900, 8'h12);
    wr(8'h90, 8'h00);
    erase(16'hF900);
    rd_nv(16'hF900, 8'h12);
    $display("nonvolatile write and erase done");
    wr(8'h90, 8'h04);
    erase(16'hF800);
    snap = active_config;
    go(NVA, 16'hF805, 8'h00);
    go(NVW, 16'h0000, 8'h5A);
    repeat (2) @(posedge core_clk);
    chk8(active_config[47:40], snap[47:40]);
    wr(8'hD8, 8'h01);
    repeat (NR + 10) @(posedge core_clk);
    chk8(active_config[47:40], 8'h5A);
    chk8(active_config[7:0], 8'hFF);
    $display("user download done");
    go(NVA, 16'hFA00, 8'h00);
    seq_running = 1'h1;
    go(NVR, 16'h0000, 8'h00);
    chk1(ack, 1'h0);
    seq_running = 1'h0;
    go(NVR, 16'h0000, 8'h00);
    chk1(ack, 1'h1);
    fault_rec_enabled = 1'h1;
    fault_trigger_any = 1'h1;
    rd_nv(16'hF900, 8'hFF);
    chk1(ack, 1'h1);
    fault_trigger_any = 1'h0;
    rd_nv(16'hF900, 8'h12);
    $display("access rules done");
    erase(16'hFA28);
    go(NVA, 16'hFA28, 8'h00);
    go(NVW, 16'h0000, 8'h6B);
    advance(6'h05);
    chk1(hits == 1, 1'h1);
    chk8(seq_word[7:0], 8'h6B);
    chk8(seq_word[63:56], 8'hFF);
    advance(6'h3F);
    chk1(hits == 0, 1'h1);
    $display("state fetch done");
    tally_and_finish();
  end
endmodule : test_config_download_and_update
